/* verilog/scad_pkg.sv */
`default_nettype none
package scad_pkg;
    // ------------------------------------------------------------
    // opcode patterns and field positions
    // ------------------------------------------------------------
    localparam logic [6:0] SCAD_OP_SUB_RM = 7'h14;   // 0010100w
    localparam logic [6:0] SCAD_OP_SUB_MR = 7'h15;   // 0010101w
    localparam logic [6:0] SCAD_OP_SUB_AI = 7'h16;   // 0010110w
    localparam logic [6:0] SCAD_OP_SBB_RM = 7'h0C;   // 0001100w
    localparam logic [6:0] SCAD_OP_SBB_MR = 7'h0D;   // 0001101w
    localparam logic [6:0] SCAD_OP_SBB_AI = 7'h0E;   // 0001110w
    localparam logic [6:0] SCAD_OP_CMP_RM = 7'h1C;   // 0011100w
    localparam logic [6:0] SCAD_OP_CMP_MR = 7'h1D;   // 0011101w
    localparam logic [6:0] SCAD_OP_CMP_AI = 7'h1E;   // 0011110w
    localparam logic [6:0] SCAD_OP_GRP_FF = 7'h7F;   // 1111111w
    localparam logic [6:0] SCAD_OP_GRP_F7 = 7'h7B;   // 1111011w
    localparam logic [5:0] SCAD_OP_IMM = 6'h20;      // 100000sw
    localparam logic [4:0] SCAD_OP_DECR = 5'h09;     // 01001 reg
    localparam logic [7:0] SCAD_OP_AAA = 8'h37;
    localparam logic [7:0] SCAD_OP_AAS = 8'h3F;
    localparam logic [7:0] SCAD_OP_DAA = 8'h27;
    localparam logic [7:0] SCAD_OP_DAS = 8'h2F;
    localparam logic [2:0] SCAD_SLOT_SUB = 3'h5;
    localparam logic [2:0] SCAD_SLOT_SBB = 3'h3;
    localparam logic [2:0] SCAD_SLOT_CMP = 3'h7;
    localparam logic [2:0] SCAD_SLOT_DEC = 3'h1;
    localparam logic [2:0] SCAD_SLOT_NEG = 3'h3;
    localparam logic [2:0] SCAD_SLOT_MUL = 3'h4;
    localparam logic [1:0] SCAD_MOD_REG = 2'h3;
    // ------------------------------------------------------------
    // clock counts
    // ------------------------------------------------------------
    localparam logic [5:0] SCAD_CLK_2 = 6'h02;
    localparam logic [5:0] SCAD_CLK_4 = 6'h04;
    localparam logic [5:0] SCAD_CLK_5 = 6'h05;
    localparam logic [5:0] SCAD_CLK_6 = 6'h06;
    localparam logic [5:0] SCAD_CLK_7 = 6'h07;
    localparam logic [5:0] SCAD_CLK_MUL_R_MIN = 6'h0C;  // 12
    localparam logic [5:0] SCAD_CLK_MUL_R_MAX = 6'h11;  // 17
    localparam logic [5:0] SCAD_CLK_MUL_M_MIN = 6'h0F;  // 15
    localparam logic [5:0] SCAD_CLK_MUL_M_MAX = 6'h14;  // 20
    localparam logic [5:0] SCAD_CLK_NONE = 6'h00;
    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SCAD_NONE = 4'h0,
        SCAD_MINUS = 4'h1,
        SCAD_BORROW_MINUS = 4'h2,
        SCAD_STEP_DOWN = 4'h3,
        SCAD_COMPARE = 4'h4,
        SCAD_SIGN_FLIP = 4'h5,
        SCAD_ASCII_ADD_FIX = 4'h6,
        SCAD_ASCII_MINUS_FIX = 4'h7,
        SCAD_BCD_ADD_FIX = 4'h8,
        SCAD_BCD_MINUS_FIX = 4'h9,
        SCAD_UNSIGNED_PRODUCT = 4'hA
    } scad_op_e;
    typedef enum logic [1:0] {
        SCAD_ST_IDLE = 2'b00,
        SCAD_ST_BUSY = 2'b01
    } scad_state_e;
endpackage : scad_pkg
`default_nettype wire

/* verilog/scad_counter.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// execution clock counter
// ------------------------------------------------------------
module scad_counter
    import scad_pkg::*;
#(
    parameter int CW = 6
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [CW-1:0] count,
    output logic busy,
    output logic done
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire logic one_left = (cnt_r == CW'(1));

    // load starts a count, each enabled edge takes one away until it reaches zero, then it holds
    assign cnt_nxt = load ? count : (cnt_r != '0) ? cnt_r - CW'(1) : cnt_r;
    assign busy = (cnt_r != '0);
    assign done = busy && one_left && clk_en;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : scad_counter
`default_nettype wire

/* verilog/scad_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// [RL1] subtract 0010100w is 7 clocks, 0010101w is 6 clocks, addressing byte follows
// [RL2] subtract immediate 100000sw slot 101: 2 register, 7 memory
// [RL3] subtract accumulator short form 0010110w takes 2 clocks
// [RL4] borrow subtract register pair 000110dw takes 2 clocks
// [RL5] borrow subtract 0001100w is 7 clocks, 0001101w is 6 clocks
// [RL6] borrow subtract immediate 100000sw slot 011: 2 register, 7 memory
// [RL7] borrow subtract accumulator short form 0001110w takes 2 clocks
// [RL8] decrement 1111111w slot 001 is 2/6; short 01001reg is 2
// [RL9] compare register pair 2, 0011100w 5, 0011101w 6 clocks
// [RL10] compare immediate 100000sw slot 111: 2 register, 5 memory
// [RL11] compare accumulator short form 0011110w takes 2 clocks
// [RL12] sign flip 1111011w slot 011: 2 register, 6 memory
// [RL13] 00110111 ascii add fix, 00111111 ascii minus fix, 4 clocks
// [RL14] 00100111 bcd add fix, 00101111 bcd minus fix, 4 clocks
// [RL15] product 1111011w slot 100, byte: 12-17 register, 15-20 memory
// [RL16] w picks byte or full size, s sign-extends, d picks direction
// [RL17] paired counts: first for register operand, second for memory
// [RL18] same counts in real, virtual-8086 and protected modes
module scad_decoder
    import scad_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic insn_valid,
    output logic insn_ready,
    input wire logic [7:0] opcode,
    input wire logic [7:0] modrm,
    input wire logic [1:0] cpu_mode,
    input wire logic [5:0] mul_extra,
    output logic [3:0] op_code,
    output logic op_byte,
    output logic op_sext_imm,
    output logic op_reg_is_dest,
    output logic op_mem,
    output logic op_has_modrm,
    output logic op_has_imm,
    output logic [2:0] op_reg,
    output logic [5:0] op_clocks,
    output logic op_illegal,
    output logic exec_busy,
    output logic exec_done
);
    // ------------------------------------------------------------
    // opcode field decode
    // ------------------------------------------------------------
    wire logic [6:0] hi7 = opcode[7:1];
    wire logic [5:0] hi6 = opcode[7:2];
    wire logic [2:0] slot = modrm[5:3];
    wire logic is_mem = (modrm[7:6] != SCAD_MOD_REG); // [RL17]
    wire logic sub_rm = (hi7 == SCAD_OP_SUB_RM);
    wire logic sub_mr = (hi7 == SCAD_OP_SUB_MR);
    wire logic sub_ai = (hi7 == SCAD_OP_SUB_AI);
    wire logic sbb_rm = (hi7 == SCAD_OP_SBB_RM);
    wire logic sbb_mr = (hi7 == SCAD_OP_SBB_MR);
    wire logic sbb_ai = (hi7 == SCAD_OP_SBB_AI);
    wire logic cmp_rm = (hi7 == SCAD_OP_CMP_RM);
    wire logic cmp_mr = (hi7 == SCAD_OP_CMP_MR);
    wire logic cmp_ai = (hi7 == SCAD_OP_CMP_AI);
    wire logic imm_grp = (hi6 == SCAD_OP_IMM);
    wire logic ff_grp = (hi7 == SCAD_OP_GRP_FF);
    wire logic f7_grp = (hi7 == SCAD_OP_GRP_F7);
    wire logic dec_short = (opcode[7:3] == SCAD_OP_DECR);
    wire logic adj_aaa = (opcode == SCAD_OP_AAA);
    wire logic adj_aas = (opcode == SCAD_OP_AAS);
    wire logic adj_daa = (opcode == SCAD_OP_DAA);
    wire logic adj_das = (opcode == SCAD_OP_DAS);
    wire logic imm_sub = imm_grp && (slot == SCAD_SLOT_SUB);
    wire logic imm_sbb = imm_grp && (slot == SCAD_SLOT_SBB);
    wire logic imm_cmp = imm_grp && (slot == SCAD_SLOT_CMP);
    wire logic ff_dec = ff_grp && (slot == SCAD_SLOT_DEC);
    wire logic f7_neg = f7_grp && (slot == SCAD_SLOT_NEG);
    wire logic f7_mul = f7_grp && (slot == SCAD_SLOT_MUL);
    wire logic one_byte = dec_short || adj_aaa || adj_aas || adj_daa || adj_das;
    wire logic short_ai = sub_ai || sbb_ai || cmp_ai;
    wire logic modrm_fmt = sub_rm || sub_mr || sbb_rm || sbb_mr || cmp_rm || cmp_mr
                           || imm_sub || imm_sbb || imm_cmp || ff_dec || f7_neg || f7_mul;
    wire logic known = one_byte || short_ai || modrm_fmt;
    // two-operand forms: memory addressing gives the fixed count, register pair 2
    wire logic two_op = sub_rm || sub_mr || sbb_rm || sbb_mr || cmp_rm || cmp_mr;
    // multiply range picked by the datapath's early-out; clamp keeps it legal
    wire logic [5:0] mul_min = is_mem ? SCAD_CLK_MUL_M_MIN : SCAD_CLK_MUL_R_MIN;
    wire logic [5:0] mul_max = is_mem ? SCAD_CLK_MUL_M_MAX : SCAD_CLK_MUL_R_MAX;
    // one spare bit: min plus a large early-out value must not wrap below the minimum
    wire logic [6:0] mul_sum = {1'b0, mul_min} + {1'b0, mul_extra};
    wire logic [5:0] mul_clk = (mul_sum > {1'b0, mul_max}) ? mul_max : mul_sum[5:0]; // [RL15]

    // ------------------------------------------------------------
    // operation and clock count selection, mode-independent
    // ------------------------------------------------------------
    wire logic [3:0] op_sel =
        (sub_rm || sub_mr || sub_ai || imm_sub) ? 4'(SCAD_MINUS) :
        (sbb_rm || sbb_mr || sbb_ai || imm_sbb) ? 4'(SCAD_BORROW_MINUS) :
        (cmp_rm || cmp_mr || cmp_ai || imm_cmp) ? 4'(SCAD_COMPARE) :
        (ff_dec || dec_short) ? 4'(SCAD_STEP_DOWN) :
        f7_neg ? 4'(SCAD_SIGN_FLIP) :
        f7_mul ? 4'(SCAD_UNSIGNED_PRODUCT) :
        adj_aaa ? 4'(SCAD_ASCII_ADD_FIX) :
        adj_aas ? 4'(SCAD_ASCII_MINUS_FIX) :
        adj_daa ? 4'(SCAD_BCD_ADD_FIX) :
        adj_das ? 4'(SCAD_BCD_MINUS_FIX) : 4'(SCAD_NONE); // [RL13] [RL14]
    wire logic [5:0] clk_sel =
        (two_op && !is_mem) ? SCAD_CLK_2 :                 // [RL4] [RL9]
        (sub_rm || sbb_rm) ? SCAD_CLK_7 :                  // [RL1] [RL5]
        (sub_mr || sbb_mr || cmp_mr) ? SCAD_CLK_6 :        // [RL1] [RL5] [RL9]
        cmp_rm ? SCAD_CLK_5 :                              // [RL9]
        short_ai ? SCAD_CLK_2 :                            // [RL3] [RL7] [RL11]
        (imm_sub || imm_sbb) ? (is_mem ? SCAD_CLK_7 : SCAD_CLK_2) : // [RL2] [RL6]
        imm_cmp ? (is_mem ? SCAD_CLK_5 : SCAD_CLK_2) :     // [RL10]
        (ff_dec || f7_neg) ? (is_mem ? SCAD_CLK_6 : SCAD_CLK_2) : // [RL8] [RL12]
        dec_short ? SCAD_CLK_2 :                           // [RL8]
        f7_mul ? mul_clk :
        (adj_aaa || adj_aas || adj_daa || adj_das) ? SCAD_CLK_4 : SCAD_CLK_NONE;
    // cpu_mode is deliberately not used in the count [RL18]

    // ------------------------------------------------------------
    // handshake: one instruction at a time
    // ------------------------------------------------------------
    scad_state_e state_r;
    logic busy;
    logic take;
    assign insn_ready = (state_r == SCAD_ST_IDLE);
    assign take = insn_valid && insn_ready && clk_en;
    assign exec_busy = busy;

    scad_counter #(
        .CW(6)
    ) u_counter (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .load(take && known),
        .count(clk_sel),
        .busy(busy),
        .done(exec_done)
    );

    // state: busy from a take of a known instruction until the counter runs out
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= SCAD_ST_IDLE;
        end else if (clk_en) begin
            if (take && known) begin
                state_r <= SCAD_ST_BUSY;
            end else if (exec_done) begin
                state_r <= SCAD_ST_IDLE;
            end
        end
    end

    // decoded fields latched on take
    always_ff @(posedge core_clk) begin
        if (reset) begin
            op_code <= 4'(SCAD_NONE);
            op_byte <= 1'b0;
            op_sext_imm <= 1'b0;
            op_reg_is_dest <= 1'b0;
            op_mem <= 1'b0;
            op_has_modrm <= 1'b0;
            op_has_imm <= 1'b0;
            op_reg <= 3'h0;
            op_clocks <= SCAD_CLK_NONE;
            op_illegal <= 1'b0;
        end else if (take) begin
            op_code <= op_sel;
            op_byte <= !opcode[0] && !dec_short;              // [RL16]
            op_sext_imm <= imm_grp && opcode[1];               // [RL16]
            op_reg_is_dest <= two_op && opcode[1];             // [RL16]
            op_mem <= modrm_fmt && is_mem;
            op_has_modrm <= modrm_fmt;
            op_has_imm <= short_ai || imm_sub || imm_sbb || imm_cmp;
            op_reg <= dec_short ? opcode[2:0] : modrm[2:0];
            op_clocks <= clk_sel;
            op_illegal <= !known;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sub_mem_seven: assert property (@(posedge core_clk) disable iff (reset)
        take && sub_rm && is_mem |=> op_clocks == SCAD_CLK_7) // [RL1]
        else $error("subtract from memory count wrong");
    a_imm_sub_count: assert property (@(posedge core_clk) disable iff (reset)
        take && imm_sub |=> op_clocks == ($past(is_mem) ? SCAD_CLK_7 : SCAD_CLK_2)) // [RL2]
        else $error("immediate subtract count wrong");
    a_short_acc_two: assert property (@(posedge core_clk) disable iff (reset)
        take && short_ai |=> op_clocks == SCAD_CLK_2 && op_has_imm) // [RL3]
        else $error("short accumulator count wrong");
    a_sbb_reg_pair: assert property (@(posedge core_clk) disable iff (reset)
        take && sbb_rm && !is_mem |=> op_clocks == SCAD_CLK_2
        && op_code == 4'(SCAD_BORROW_MINUS)) // [RL4]
        else $error("borrow register pair count wrong");
    a_cmp_imm_count: assert property (@(posedge core_clk) disable iff (reset)
        take && imm_cmp && is_mem |=> op_clocks == SCAD_CLK_5) // [RL10]
        else $error("compare immediate memory count wrong");
    a_neg_mem_six: assert property (@(posedge core_clk) disable iff (reset)
        take && f7_neg && is_mem |=> op_clocks == SCAD_CLK_6) // [RL12]
        else $error("sign flip memory count wrong");
    a_adjust_four: assert property (@(posedge core_clk) disable iff (reset)
        take && (adj_aaa || adj_das) |=> op_clocks == SCAD_CLK_4) // [RL13] [RL14]
        else $error("adjust count wrong");
    a_mul_in_range: assert property (@(posedge core_clk) disable iff (reset)
        take && f7_mul && !is_mem |=> op_clocks >= SCAD_CLK_MUL_R_MIN
        && op_clocks <= SCAD_CLK_MUL_R_MAX) // [RL15]
        else $error("product count out of range");
    a_cmp_mem_six: assert property (@(posedge core_clk) disable iff (reset)
        take && cmp_mr && is_mem |=> op_clocks == SCAD_CLK_6) // [RL9]
        else $error("compare register with memory count wrong");
    a_mul_mem_range: assert property (@(posedge core_clk) disable iff (reset)
        take && f7_mul && is_mem |=> op_clocks >= SCAD_CLK_MUL_M_MIN
        && op_clocks <= SCAD_CLK_MUL_M_MAX) // [RL15]
        else $error("product memory count out of range");
    // second cycle ends the count unless a stall held it back
    a_dec_busy_len: assert property (@(posedge core_clk) disable iff (reset)
        take && dec_short |=> exec_busy ##1 (!clk_en || !$past(clk_en) || exec_done)) // [RL8]
        else $error("decrement did not end after two clocks");
    c_mul_mem: cover property (@(posedge core_clk) take && f7_mul && is_mem);
    c_cmp_short: cover property (@(posedge core_clk) take && cmp_ai);
    c_done: cover property (@(posedge core_clk) exec_done);
    c_illegal: cover property (@(posedge core_clk) take && !known);
endmodule : scad_decoder
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import scad_pkg::*;
    // expected decode of one taken instruction
    typedef struct {
        logic [3:0] op;
        logic [5:0] clk;
        logic mem;
        logic ill;
        logic [1:0] fk;   // 1 checks s bit, 2 checks d bit
        logic fv;
        logic bk;
        logic bv;
        logic hm;         // has addressing byte
        logic hi;         // has immediate data
        logic rk;         // register field is checked
        logic [2:0] rg;
    } scad_exp_s;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic insn_valid = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [7:0] modrm = 8'h00;
    logic [1:0] cpu_mode = 2'h0;
    logic [5:0] mul_extra = 6'h00;
    logic insn_ready, op_byte, op_sext_imm, op_reg_is_dest, op_mem, op_has_modrm, op_has_imm;
    logic op_illegal, exec_busy, exec_done;
    logic [3:0] op_code;
    logic [2:0] op_reg;
    logic [5:0] op_clocks;
    logic stall_on = 1'b0;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    scad_exp_s expq[$];

    scad_decoder scad_decoder_i (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .insn_valid(insn_valid), .insn_ready(insn_ready), .opcode(opcode), .modrm(modrm),
        .cpu_mode(cpu_mode), .mul_extra(mul_extra), .op_code(op_code), .op_byte(op_byte),
        .op_sext_imm(op_sext_imm), .op_reg_is_dest(op_reg_is_dest), .op_mem(op_mem),
        .op_has_modrm(op_has_modrm), .op_has_imm(op_has_imm), .op_reg(op_reg),
        .op_clocks(op_clocks), .op_illegal(op_illegal), .exec_busy(exec_busy),
        .exec_done(exec_done));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    // --------------------------------------------------------
    // compare and closing tasks
    // --------------------------------------------------------
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input logic [5:0] exp);
        n_compared++;
        if (got !== int'(exp)) begin
            fail_count++;
            $display("CHECK FAILED %0t busy cycles %0d exp %0d", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // hang guard, far above the thousand or so cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            $display("CHECK FAILED %0t run did not finish", $time);
            results();
        end
    end

    // random clock-enable stalls, only in the late phase
    always @(negedge core_clk) begin
        clk_en <= stall_on ? ($urandom_range(0, 3) != 0) : 1'b1;
    end

    // --------------------------------------------------------
    // driver: flags are {has modrm, check w, field kind}
    // --------------------------------------------------------
    task automatic issue(input logic [7:0] opc, input logic [7:0] mrm, input logic [3:0] op,
            input logic [5:0] clk, input logic [3:0] fl);
        scad_exp_s e;
        int w;
        @(negedge core_clk);
        opcode = opc;
        modrm = mrm;
        cpu_mode = 2'($urandom_range(0, 3));
        mul_extra = 6'($urandom_range(0, 63));
        insn_valid = 1'b1;
        e.op = op;
        e.ill = (op == SCAD_NONE);
        e.mem = fl[3] && (mrm[7:6] != 2'h3);
        e.clk = clk;
        e.fk = fl[1:0];
        e.fv = opc[1];
        e.bk = fl[2];
        e.bv = ~opc[0];
        e.hm = fl[3];
        e.hi = (fl[1:0] == 2'h1) || (fl == 4'h4 && op != SCAD_STEP_DOWN);
        e.rk = fl[3] || (op == SCAD_STEP_DOWN);
        e.rg = fl[3] ? mrm[2:0] : opc[2:0];
        if (op == SCAD_UNSIGNED_PRODUCT) begin
            w = (e.mem ? 15 : 12) + int'(mul_extra);
            e.clk = 6'((w > (e.mem ? 20 : 17)) ? (e.mem ? 20 : 17) : w);
        end
        // note queued before the take edge so the monitor always finds it
        expq.push_back(e);
        w = 0;
        do begin
            @(posedge core_clk);
            w++;
        end while (!(insn_ready === 1'b1 && clk_en === 1'b1) && w < 200);
        @(negedge core_clk);
        insn_valid = 1'b0;
    endtask : issue

    // --------------------------------------------------------
    // monitor: takes the oldest note at each accepted instruction
    // --------------------------------------------------------
    initial begin : mon
        scad_exp_s e;
        int n;
        forever begin
            @(posedge core_clk);
            if (reset === 1'b0 && insn_valid === 1'b1 && insn_ready === 1'b1
                    && clk_en === 1'b1 && expq.size() > 0) begin
                @(posedge core_clk);
                e = expq.pop_front();
                chk_val(op_code, e.op, "operation");
                chk_val(op_illegal, e.ill, "illegal flag");
                if (e.ill) begin
                    chk_val(exec_busy, 1'b0, "busy on illegal");
                end else begin
                    chk_val(op_mem, e.mem, "memory operand");
                    chk_val(op_clocks, e.clk, "clock count");
                    if (e.fk == 2'h1) chk_val(op_sext_imm, e.fv, "sign extend");
                    if (e.fk == 2'h2) chk_val(op_reg_is_dest, e.fv, "direction");
                    if (e.bk) chk_val(op_byte, e.bv, "byte size");
                    chk_val(op_has_modrm, e.hm, "addressing byte");
                    chk_val(op_has_imm, e.hi, "immediate data");
                    if (e.rk) chk_val(op_reg, e.rg, "register field");
                    n = 0;
                    forever begin
                        if (clk_en === 1'b1 && exec_busy === 1'b1) n++;
                        if ((clk_en === 1'b1 && exec_done === 1'b1) || n > 64) break;
                        @(posedge core_clk);
                    end
                    chk_cnt(n, e.clk);
                end
            end
        end
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin : main
        logic [2:0] sl[3] = '{3'h5, 3'h3, 3'h7};
        logic [3:0] ops[3] = '{SCAD_MINUS, SCAD_BORROW_MINUS, SCAD_COMPARE};
        logic [5:0] mc[3] = '{6'h07, 6'h07, 6'h05};
        logic [7:0] m;
        int k;
        void'($urandom(34087));
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk_val(insn_ready, 1'b1, "ready in reset");
        reset = 1'b0;
        issue(8'h28, 8'h00, SCAD_MINUS, 6'h07, 4'hE);
        issue(8'h2B, 8'h45, SCAD_MINUS, 6'h06, 4'hE);
        issue(8'h29, 8'hC1, SCAD_MINUS, 6'h02, 4'hE);
        issue(8'h83, 8'hE8, SCAD_MINUS, 6'h02, 4'hD);
        issue(8'h81, 8'h68, SCAD_MINUS, 6'h07, 4'hD);
        issue(8'h2D, 8'h00, SCAD_MINUS, 6'h02, 4'h4);
        issue(8'h1A, 8'hC0, SCAD_BORROW_MINUS, 6'h02, 4'hE);
        issue(8'h19, 8'h00, SCAD_BORROW_MINUS, 6'h07, 4'hE);
        issue(8'h1A, 8'h40, SCAD_BORROW_MINUS, 6'h06, 4'hE);
        issue(8'h80, 8'hD8, SCAD_BORROW_MINUS, 6'h02, 4'hD);
        issue(8'h83, 8'h18, SCAD_BORROW_MINUS, 6'h07, 4'hD);
        issue(8'h1C, 8'h00, SCAD_BORROW_MINUS, 6'h02, 4'h4);
        issue(8'hFE, 8'hC8, SCAD_STEP_DOWN, 6'h02, 4'hC);
        issue(8'hFF, 8'h0E, SCAD_STEP_DOWN, 6'h06, 4'hC);
        issue(8'h4B, 8'h00, SCAD_STEP_DOWN, 6'h02, 4'h4);
        issue(8'h3A, 8'hC0, SCAD_COMPARE, 6'h02, 4'hE);
        issue(8'h38, 8'h80, SCAD_COMPARE, 6'h05, 4'hE);
        issue(8'h3B, 8'h00, SCAD_COMPARE, 6'h06, 4'hE);
        issue(8'h80, 8'hF8, SCAD_COMPARE, 6'h02, 4'hD);
        issue(8'h81, 8'h38, SCAD_COMPARE, 6'h05, 4'hD);
        issue(8'h3D, 8'h00, SCAD_COMPARE, 6'h02, 4'h4);
        issue(8'hF6, 8'hD8, SCAD_SIGN_FLIP, 6'h02, 4'hC);
        issue(8'hF7, 8'h18, SCAD_SIGN_FLIP, 6'h06, 4'hC);
        issue(8'h37, 8'h00, SCAD_ASCII_ADD_FIX, 6'h04, 4'h0);
        issue(8'h3F, 8'h00, SCAD_ASCII_MINUS_FIX, 6'h04, 4'h0);
        issue(8'h27, 8'h00, SCAD_BCD_ADD_FIX, 6'h04, 4'h0);
        issue(8'h2F, 8'h00, SCAD_BCD_MINUS_FIX, 6'h04, 4'h0);
        issue(8'h00, 8'hC0, SCAD_NONE, 6'h00, 4'hC);
        for (k = 0; k < 8; k++) begin
            issue(8'hF6 | 8'(k % 2), (k > 3) ? 8'h20 : 8'hE0, SCAD_UNSIGNED_PRODUCT, 6'h00, 4'hC);
        end
        // immediate group with random fields under clock-enable stalls
        stall_on = 1'b1;
        for (int i = 0; i < 24; i++) begin
            k = $urandom_range(0, 2);
            m = {2'($urandom_range(0, 3)), sl[k], 3'($urandom_range(0, 7))};
            issue(8'h80 | 8'($urandom_range(0, 3)), m, ops[k],
                (m[7:6] == 2'h3) ? 6'h02 : mc[k], 4'hD);
        end
        repeat (200) @(posedge core_clk);
        results();
    end
endmodule : tb
`default_nettype wire
